// file: core/srcs_pkg.sv
// constants, field layout and state codes of the reset and clock sequencer
package srcs_pkg;
    // sequencing counter, counted in internal oscillator cycles
    localparam int             CNT_W           = 13;
    localparam logic [12:0]    POR_TIMEOUT_CYC = 13'h1000; // 4096
    localparam logic [12:0]    RECOV_POR_CYC   = 13'h1043; // 4163
    localparam logic [12:0]    RECOV_OTHER_CYC = 13'h0043; // 67
    localparam logic [12:0]    STOP_LONG_CYC   = 13'h1000; // 4096
    localparam logic [12:0]    STOP_SHORT_CYC  = 13'h0020; // 32
    // minimum external reset pulse, time and bus clock
    localparam int             RST_MIN_NS      = 100;
    localparam int             CLK_PERIOD_NS   = 20;
    localparam int             RST_MIN_CYC     =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset vectors
    localparam logic [15:0]    VEC_NORMAL      = 16'hFFFE;
    localparam logic [15:0]    VEC_MONITOR     = 16'hFEFE;
    // reset cause bit positions
    localparam int             NCAUSE          = 6;
    localparam int             CB_POR          = 0;
    localparam int             CB_PIN          = 1;
    localparam int             CB_WDOG         = 2;
    localparam int             CB_ILOP         = 3;
    localparam int             CB_ILAD         = 4;
    localparam int             CB_LVI          = 5;
    // register byte offsets
    localparam int             AW              = 12;
    localparam logic [11:0]    OFS_CAUSE       = 12'h000;
    localparam logic [11:0]    OFS_MASK        = 12'h004;
    localparam logic [11:0]    OFS_CTRL        = 12'h008;
    localparam logic [11:0]    OFS_STATE       = 12'h00C;
    // control register fields and reset values
    localparam int             CTL_STOP_SHORT  = 0;
    localparam int             CTL_WAIT_A      = 1;
    localparam int             CTL_WAIT_B      = 2;
    localparam logic [2:0]     CTRL_RST        = 3'h0;
    localparam logic [5:0]     MASK_RST        = 6'h00;
    localparam int             ST_CNT_LSB      = 16;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_POR   = 3'b001,
        ST_RECOV = 3'b010,
        ST_PIN   = 3'b011,
        ST_STOP  = 3'b100,
        ST_SDLY  = 3'b101
    } srcs_state_e;
endpackage

// file: core/srcs_sync.sv
// two flip-flop synchroniser for pins entering the bus clock domain
module srcs_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,    // bus clock
    input  wire logic rst_n,  // async reset, active low
    input  wire logic ce,     // clock enable
    input  wire logic d,      // asynchronous input
    output logic      q       // synchronised level
);
    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end
        else if (ce)
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// file: core/srcs_osc_counter.sv
// oscillator cycle counter with clear and start mark
module srcs_osc_counter #(
    parameter int W = 13
) (
    input  wire logic         clk,     // bus clock
    input  wire logic         rst_n,   // async reset, active low
    input  wire logic         ce,      // clock enable
    input  wire logic         tick,    // one oscillator cycle
    input  wire logic         clr,     // clear count and mark
    input  wire logic         mark,    // start measuring, keep count
    output logic [W-1:0]      elapsed  // cycles since clear or mark
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] base_r;

    // a mark keeps the count, so a pin reset leaves it untouched
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r  <= '0;
            base_r <= '0;
        end
        else if (ce)
        begin
            if (clr)
            begin
                cnt_r  <= '0;
                base_r <= '0;
            end
            else
            begin
                if (tick)
                    cnt_r <= cnt_r + 1'b1;
                // base follows this tick so the mark cycle reads zero
                if (mark)
                    base_r <= cnt_r + W'(tick);
            end
        end
    end

    // wrap of the difference is harmless, no wait exceeds 2**W
    assign elapsed = cnt_r - base_r;
endmodule

// file: core/srcs_top.sv
// reset and clock start sequencer with apb status and control
module srcs_top
    import srcs_pkg::*;
#(
    parameter logic [12:0] POR_CYCLES   = POR_TIMEOUT_CYC, // power-on hold
    parameter logic [12:0] RECOV_CYCLES = RECOV_POR_CYC,   // power-on total
    parameter int          PIN_MIN_CYC  = RST_MIN_CYC      // pin low minimum
) (
    input  wire logic          pclk,            // bus clock
    input  wire logic          presetn,         // async reset, active low
    input  wire logic          clk_en,          // freezes all state when low
    input  wire logic          psel,            // apb select
    input  wire logic          penable,         // apb enable
    input  wire logic          pwrite,          // apb direction
    input  wire logic [11:0]   paddr,           // apb byte address
    input  wire logic [31:0]   pwdata,          // apb write data
    output logic [31:0]        prdata,          // apb read data
    output logic               pready,          // apb ready
    output logic               pslverr,         // apb error
    input  wire logic          osc_tick,        // oscillator cycle strobe
    input  wire logic          por_det,         // power-on detect, async
    input  wire logic          rst_pin_i,       // reset pin level, async
    output logic               rst_pin_o,       // reset pin drive value
    output logic               rst_pin_oe,      // reset pin drive enable
    input  wire logic          wdog_rst,        // watchdog timeout
    input  wire logic          lvi_rst,         // low-voltage inhibit
    input  wire logic          illop_rst,       // illegal opcode
    input  wire logic          illad_rst,       // illegal address
    input  wire logic          monitor_mode,    // selects monitor vector
    input  wire logic          stop_req,        // enter stop mode
    input  wire logic          stop_exit,       // interrupt or break wake
    input  wire logic          wait_mode,       // wait mode level
    output logic               internal_reset_line,            // internal reset line
    output logic [15:0]        reset_vec,       // reset vector address
    output logic               bus_clk_en,      // internal bus clocks
    output logic               cpu_clk_en,      // cpu clocks
    output logic               periph_clk_en,   // peripheral clocks
    output logic [1:0]         wait_clk_en,     // wait-capable clock sets
    output logic               irq              // cause interrupt, level
);
    // elaboration guard
    generate
        if (RECOV_CYCLES <= POR_CYCLES || PIN_MIN_CYC < 1)
        begin : g_bad_param
            $error("srcs_top: bad timing parameters");
        end
    endgenerate

    srcs_state_e       state_r, state_nxt;
    logic [12:0]       tgt_r, tgt_nxt;
    logic [12:0]       elapsed;
    logic              cnt_clr, cnt_mark;
    logic              por_s, pin_s, pin_low;
    logic              other_int, any_int;
    logic [NCAUSE-1:0] set_v, cause_r, cause_nxt, clr_v, mask_r;
    logic [2:0]        ctrl_r;
    logic [7:0]        pin_cnt_r;
    logic [1:0]        oe_hist_r;
    logic              internal_reset_line_nxt, bus_nxt;
    logic              rd_cap, wr_en;

    // pins pass two flip-flops first
    srcs_sync #(.RST_VAL(1'b1)) u_por_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .d     (por_det),
        .q     (por_s)
    );
    srcs_sync #(.RST_VAL(1'b1)) u_pin_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .d     (rst_pin_i),
        .q     (pin_s)
    );

    // one counter for all timeouts
    srcs_osc_counter #(.W(CNT_W)) u_cnt (
        .clk     (pclk),
        .rst_n   (presetn),
        .ce      (clk_en),
        .tick    (osc_tick),
        .clr     (cnt_clr),
        .mark    (cnt_mark),
        .elapsed (elapsed)
    );

    // own drive masked until the synchroniser has seen its release
    assign pin_low   = ~pin_s & ~rst_pin_oe & ~|oe_hist_r;
    assign other_int = wdog_rst | illop_rst | illad_rst;
    assign any_int   = por_s | lvi_rst | other_int;

    // sequencing: power-on and low voltage outrank all other sources
    always_comb
    begin
        state_nxt = state_r;
        tgt_nxt   = tgt_r;
        cnt_clr   = 1'b0;
        cnt_mark  = 1'b0;
        set_v     = '0;
        if (por_s | lvi_rst)
        begin
            // held source keeps clearing, timeout runs after release
            state_nxt      = ST_POR;
            cnt_clr        = 1'b1;
            tgt_nxt        = RECOV_CYCLES;
            set_v[CB_POR]  = por_s;
            set_v[CB_LVI]  = lvi_rst & ~por_s;
        end
        else if (other_int && state_r != ST_POR)
        begin
            state_nxt      = ST_RECOV;
            cnt_clr        = 1'b1;
            tgt_nxt        = RECOV_OTHER_CYC;
            set_v[CB_WDOG] = wdog_rst;
            set_v[CB_ILOP] = illop_rst;
            set_v[CB_ILAD] = illad_rst;
        end
        else
        begin
            case (state_r)
                ST_RUN:
                begin
                    if (pin_low)
                        state_nxt = ST_PIN;
                    else if (stop_req)
                        state_nxt = ST_STOP;
                end
                ST_POR:
                begin
                    if (elapsed >= POR_CYCLES)
                        state_nxt = ST_RECOV;
                end
                ST_RECOV:
                begin
                    if (elapsed >= tgt_r)
                        state_nxt = ST_RUN;
                end
                ST_PIN:
                begin
                    if (!pin_low)
                    begin
                        // pin reset measures from a mark, count kept
                        state_nxt = ST_RECOV;
                        cnt_mark  = 1'b1;
                        tgt_nxt   = RECOV_OTHER_CYC;
                    end
                end
                ST_STOP:
                begin
                    if (pin_low)
                        state_nxt = ST_PIN;
                    else if (stop_exit)
                    begin
                        state_nxt = ST_SDLY;
                        cnt_clr   = 1'b1;
                        tgt_nxt   = ctrl_r[CTL_STOP_SHORT] ?
                                    STOP_SHORT_CYC : STOP_LONG_CYC;
                    end
                end
                ST_SDLY:
                begin
                    if (elapsed >= tgt_r)
                        state_nxt = ST_RUN;
                end
                default:
                    state_nxt = ST_RUN;
            endcase
        end
        // pin cause only when no internal source is present
        if (pin_low && !any_int && pin_cnt_r >= 8'(PIN_MIN_CYC - 1))
            set_v[CB_PIN] = 1'b1;
    end

    // state, target
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_POR;
            tgt_r   <= RECOV_POR_CYC;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            tgt_r   <= tgt_nxt;
        end
    end

    // pin low duration, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_cnt_r <= 8'h00;
        else if (clk_en)
        begin
            if (!pin_low)
                pin_cnt_r <= 8'h00;
            else if (pin_cnt_r != 8'hFF)
                pin_cnt_r <= pin_cnt_r + 8'h01;
        end
    end

    assign internal_reset_line_nxt = (state_nxt == ST_POR) || (state_nxt == ST_RECOV) ||
                      (state_nxt == ST_PIN);
    assign bus_nxt  = (state_nxt == ST_RUN) || (state_nxt == ST_RECOV) ||
                      (state_nxt == ST_PIN);

    // reset line, pin drive, vector and clock gates, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            internal_reset_line          <= 1'b1;
            rst_pin_oe    <= 1'b1;
            oe_hist_r     <= 2'b11;
            reset_vec     <= VEC_NORMAL;
            bus_clk_en    <= 1'b0;
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
            wait_clk_en   <= 2'b00;
        end
        else if (clk_en)
        begin
            internal_reset_line       <= internal_reset_line_nxt;
            rst_pin_oe <= (state_nxt == ST_POR) ||
                          (state_nxt == ST_RECOV);
            oe_hist_r     <= {oe_hist_r[0], rst_pin_oe};
            if (internal_reset_line_nxt)
                reset_vec <= monitor_mode ? VEC_MONITOR : VEC_NORMAL;
            bus_clk_en    <= bus_nxt;
            periph_clk_en <= bus_nxt;
            cpu_clk_en    <= bus_nxt & ~wait_mode;
            wait_clk_en[0] <= bus_nxt &
                              (~wait_mode | ctrl_r[CTL_WAIT_A]);
            wait_clk_en[1] <= bus_nxt &
                              (~wait_mode | ctrl_r[CTL_WAIT_B]);
        end
    end

    // the pin is open drain: only ever pulled low
    assign rst_pin_o = 1'b0;

    // apb: one wait state so that data and ready come from flops
    assign rd_cap = psel & penable & ~pready & ~pwrite;
    assign wr_en  = psel & penable & pready & pwrite;
    assign clr_v  = (rd_cap && paddr == OFS_CAUSE) ? cause_r : '0;
    // a new event in the clearing cycle survives
    assign cause_nxt = (cause_r & ~clr_v) | set_v;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready)
            begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    OFS_CAUSE: prdata[NCAUSE-1:0] <= cause_r;
                    OFS_MASK:  prdata[NCAUSE-1:0] <= mask_r;
                    OFS_CTRL:  prdata[2:0] <= ctrl_r;
                    OFS_STATE:
                    begin
                        prdata[2:0] <= state_r;
                        prdata[ST_CNT_LSB +: CNT_W] <= elapsed;
                    end
                    default:   pslverr <= 1'b1;
                endcase
            end
        end
    end

    // cause survives internal reset; only presetn or a read of OFS_CAUSE clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cause_r <= '0;
        else if (clk_en)
            cause_r <= cause_nxt;
    end

    // mask and control: written in the access phase, defaulted by internal_reset_line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
        end
        else if (clk_en && internal_reset_line)
        begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
        end
        else if (clk_en && wr_en)
        begin
            if (paddr == OFS_MASK)
                mask_r <= pwdata[NCAUSE-1:0];
            if (paddr == OFS_CTRL)
                ctrl_r <= pwdata[2:0];
        end
    end

    // interrupt level from unmasked cause bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(cause_nxt & mask_r);
    end

    a_por_clk_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_POR |-> !cpu_clk_en && !periph_clk_en)
        else $error("clocks running during power-on timeout");
    a_por_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_POR |-> rst_pin_oe && !rst_pin_o)
        else $error("reset pin not driven during power-on timeout");
    a_bus_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bus_clk_en) && $past(state_r) == ST_POR
        |-> $past(elapsed) >= POR_CYCLES)
        else $error("bus clocks started before timeout");
    a_stop_delay: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_SDLY |-> !cpu_clk_en && !bus_clk_en)
        else $error("clocks running in stop delay");
    a_wait_cpu: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wait_mode |=> !cpu_clk_en)
        else $error("cpu clock running in wait mode");
    a_src_internal_reset_line: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && any_int |=> internal_reset_line && (reset_vec == VEC_NORMAL ||
        reset_vec == VEC_MONITOR))
        else $error("reset source without internal reset");
    a_int_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && other_int && state_r != ST_POR
        |=> elapsed == 13'h0000)
        else $error("internal reset did not clear counter");
    a_cause_wdog: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wdog_rst && !por_s && !lvi_rst && state_r != ST_POR
        |=> cause_r[CB_WDOG])
        else $error("watchdog cause bit not set");
    a_recov_end: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(internal_reset_line) |-> $past(elapsed) >= $past(tgt_r))
        else $error("recovery ended early");
endmodule

// file: dv/srcs_far_model.sv
// far-side model: cpu core, peripherals and the pulled-up reset pin
module srcs_far_model (
    input  wire logic       pclk,        // bus clock
    input  wire logic       rst_pin_o,   // device pin drive value
    input  wire logic       rst_pin_oe,  // device pin drive enable
    output logic            rst_pin_i,   // resolved pin level
    output logic [5:0]      ev           // wdog lvi illop illad stop wake
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ext_low;  // outside party pulls the pin down

    initial
    begin
        ext_low = 1'b0;
        ev = 6'h00;
    end

    // wired pin with pull-up: released means high, never a stale value
    assign rst_pin_i = !(ext_low || (rst_pin_oe && !rst_pin_o));

    // outside party holds the pin low for n bus cycles
    task automatic pull(input int n);
        @(posedge pclk);
        ext_low <= 1'b1;
        repeat (n) @(posedge pclk);
        ext_low <= 1'b0;
    endtask

    // one-cycle strobe on a fault, stop or wake line
    task automatic pulse(input int k);
        @(posedge pclk);
        ev[k] <= 1'b1;
        @(posedge pclk);
        ev[k] <= 1'b0;
    endtask
endmodule

// file: dv/srcs_top_tb.sv
// self-checking bench for the reset and clock start sequencer
module srcs_top_tb
    import srcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened power-on counts so the run stays brief
    localparam logic [12:0] T_POR = 13'h0010;
    localparam logic [12:0] T_REC = 13'h0053;
    localparam int          CB[4] = '{CB_WDOG, CB_LVI, CB_ILOP, CB_ILAD};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        rst_pin_o, rst_pin_oe, rst_pin_i, internal_reset_line, irq, err;
    logic        bus_clk_en, cpu_clk_en, periph_clk_en;
    logic        monitor_mode, wait_mode, clk_en, por_det;
    logic [1:0]  wait_clk_en;
    logic [15:0] reset_vec;
    logic [5:0]  ev;
    int          n_mismatch, num_checks, n, m, e;

    srcs_top #(.POR_CYCLES(T_POR), .RECOV_CYCLES(T_REC)) DUT (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_tick(1'b1), .por_det(por_det),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .wdog_rst(ev[0]), .lvi_rst(ev[1]),
        .illop_rst(ev[2]), .illad_rst(ev[3]), .monitor_mode(monitor_mode),
        .stop_req(ev[4]), .stop_exit(ev[5]), .wait_mode(wait_mode),
        .internal_reset_line(internal_reset_line), .reset_vec(reset_vec), .bus_clk_en(bus_clk_en),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .wait_clk_en(wait_clk_en), .irq(irq));

    srcs_far_model far (
        .pclk(pclk), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
        .rst_pin_i(rst_pin_i), .ev(ev));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
            chk(0, 1);
    endtask

    // cycles while internal_reset_line high (0), cpu clock off (1), bus clock off (2)
    task automatic span(input int s, output int c);
        c = 0;
        repeat (8000)
        begin
            @(posedge pclk);
            if (s == 0 ? internal_reset_line !== 1'b1 : s == 1 ? cpu_clk_en === 1'b1
                                                : bus_clk_en === 1'b1)
                break;
            c++;
        end
    endtask

    // watchdog sized well beyond the longest stop delay
    initial
    begin
        #400us;
        n_mismatch++;
        results();
    end

    initial
    begin
        n_mismatch = 0;
        num_checks = 0;
        {presetn, psel, penable, pwrite, monitor_mode, wait_mode} = 6'h00;
        paddr = 12'h000;
        clk_en = 1'b1;
        por_det = 1'b0;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // power-on: pin pulled and clocks parked through the hold
        repeat (6) @(posedge pclk);
        chk(rst_pin_oe, 1);
        chk(bus_clk_en, 0);
        span(2, n);
        chk(n + 6 >= T_POR, 1);
        chk(internal_reset_line, 1);
        span(0, m);
        chk(n + m + 6 >= T_REC && n + m <= T_REC + 4, 1);
        chk(reset_vec, VEC_NORMAL);
        apb(0, OFS_CAUSE, 0);
        chk(rd, 1 << CB_POR);
        apb(0, OFS_CAUSE, 0);
        chk(rd, 0);
        apb(0, OFS_CTRL, 0);
        chk(rd, CTRL_RST);
        apb(0, 12'h010, 0);
        chk(err, 1);
        chk(rd, 0);
        $display("test power-on done");
        // each internal source in turn; monitor vector on one
        for (int i = 0; i < 4; i++)
        begin
            apb(1, OFS_MASK, 32'h0000_003F);
            monitor_mode <= (i == 2);
            far.pulse(i);
            @(posedge pclk);
            chk(internal_reset_line, 1);
            chk(rst_pin_oe, 1);
            chk(reset_vec, i == 2 ? VEC_MONITOR : VEC_NORMAL);
            chk(bus_clk_en, i != 1);
            span(0, n);
            e = (i == 1) ? T_REC : RECOV_OTHER_CYC;
            chk(n + 2 >= e && n <= e + 4, 1);
            apb(0, OFS_MASK, 0);
            chk(rd, MASK_RST);
            chk(irq, 0);
            apb(1, OFS_MASK, 32'h0000_003F);
            repeat (2) @(posedge pclk);
            chk(irq, 1);
            apb(0, OFS_CAUSE, 0);
            chk(rd, 1 << CB[i]);
            repeat (2) @(posedge pclk);
            chk(irq, 0);
        end
        monitor_mode <= 1'b0;
        $display("test sources done");
        // pin pulled by the outside party: halt, then short recovery
        far.pull(10);
        chk(internal_reset_line, 1);
        span(0, n);
        chk(n + 10 >= RECOV_OTHER_CYC && n <= 80, 1);
        apb(0, OFS_CAUSE, 0);
        chk(rd, 1 << CB_PIN);
        $display("test pin done");
        // stop entry and exit with both delay selections
        for (int s = 1; s >= 0; s--)
        begin
            apb(1, OFS_CTRL, s);
            far.pulse(4);
            repeat (6) @(posedge pclk);
            chk({cpu_clk_en, periph_clk_en, bus_clk_en}, 0);
            far.pulse(5);
            span(1, n);
            e = s ? STOP_SHORT_CYC : STOP_LONG_CYC;
            chk(n + 2 >= e && n <= e + 6, 1);
        end
        $display("test stop done");
        // wait mode: cpu off, selected clock sets stay on
        apb(1, OFS_CTRL, 32'h0000_0002);
        wait_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(cpu_clk_en, 0);
        chk(wait_clk_en, 2'b01);
        apb(1, OFS_CTRL, 32'h0000_0006);
        repeat (2) @(posedge pclk);
        chk(wait_clk_en, 2'b11);
        wait_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(cpu_clk_en, 1);
        apb(0, OFS_STATE, 0);
        chk(rd[2:0], ST_RUN);
        $display("test wait done");
        // frozen clock enable: a fault strobe leaves no trace
        clk_en <= 1'b0;
        far.pulse(0);
        @(posedge pclk);
        chk(internal_reset_line, 0);
        clk_en <= 1'b1;
        $display("test freeze done");
        // power-on detect in mid-run: full recovery, registers defaulted
        por_det <= 1'b1;
        repeat (4) @(posedge pclk);
        por_det <= 1'b0;
        chk(internal_reset_line, 1);
        chk(bus_clk_en, 0);
        span(0, n);
        chk(n + 2 >= T_REC && n <= T_REC + 4, 1);
        apb(0, OFS_CTRL, 0);
        chk(rd, CTRL_RST);
        apb(0, OFS_CAUSE, 0);
        chk(rd, 1 << CB_POR);
        $display("test mid-run power-on done");
        results();
    end
endmodule
